// >>> core/sbc_config_diag_encoders.sv
/*
  SPI-reached configuration and diagnosis registers of the basis chip: setup, watchdog,
  reset threshold and limp-home diagnosis, with the serial read-back path.
  Assumes an SPI master in mode 0, LSB first, 16-bit frames; events come from same-clock logic.
*/
`timescale 1ns/1ps
module sbc_config_diag_encoders
    import sbc_cfg_pkg::*;
(
    input  wire logic        i_mclk,
    input  wire logic        i_reset_n,
    input  wire logic        i_spi_sclk,
    input  wire logic        i_spi_cs_n,
    input  wire logic        i_spi_sdi,
    input  wire logic [2:0]  i_sbc_mode,
    input  wire logic        i_restart_set,
    input  wire logic [1:0]  i_restart_code,
    input  wire logic        i_leave_sleep_failsafe,
    input  wire logic        i_limp_set,
    input  wire logic [2:0]  i_limp_code,
    input  wire logic        i_test_pin,
    input  wire logic        i_supply_off_strap,
    output logic             o_spi_sdo,
    output logic             o_spi_sdo_oe,
    output logic             o_lin_low_slope_sel,
    output logic [1:0]       o_can_cell_mode,
    output logic [1:0]       o_lin_cell_mode,
    output logic             o_wd_timeout_not_window,
    output logic             o_wd_enable,
    output logic [10:0]      o_wd_period_ms,
    output logic [1:0]       o_reset_thresh,
    output logic             o_limp_on,
    output logic             o_sw_dev_mode,
    output logic             o_wd_trigger,
    output logic             o_wd_bad_write,
    output logic [2:0]       o_mode_sel,
    output logic             o_mode_stb
);
    typedef struct packed {
        logic        sclk_prev;
        logic        cs_prev_n;
        logic [4:0]  bit_cnt;
        logic [15:0] rx;
        logic [2:0]  prev_sel;
        logic [8:0]  cfg;
        logic        slope;
        logic [1:0]  can_mode;
        logic [1:0]  lin_mode;
        logic [4:0]  period;
        logic        tonw;
        logic        wd_en;
        logic [10:0] period_ms;
        logic [1:0]  restart;
        logic [2:0]  limp;
        logic [2:0]  cfg_rd;
        logic        sdo;
        logic        sdo_oe;
        logic        wd_trig;
        logic        wd_bad;
        logic [2:0]  mode_out;
        logic        mode_stb;
    } state_s;

    state_s     st_q;
    state_s     st_d;
    logic [2:0] pins;

    pin_sync3 #(
        .W    (3),
        .INIT (3'h2)
    ) u_sync (
        .i_mclk    (i_mclk),
        .i_reset_n (i_reset_n),
        .i_pin     ({i_spi_sdi, i_spi_cs_n, i_spi_sclk}),
        .o_level   (pins)
    );

    // Register contents as placed in the data field
    function automatic logic [9:0] reg_data(input logic [2:0] sel, input state_s s);
        logic [9:0] d;
        d = '0;
        case (sel)
            SEL_SBC_CFG: begin
                d[8:0] = s.cfg;
            end
            SEL_COMM_SETUP: begin
                d[COMM_SLOPE]              = s.slope;
                d[COMM_CAN_LO +: 2]        = s.can_mode;
                d[COMM_LIN_LO +: 2]        = s.lin_mode;
            end
            SEL_WD_SETUP: begin
                d[WD_PERIOD_LO +: 5]       = s.period;
                d[WD_TONW]                 = s.tonw;
                d[WD_RSVD]                 = 1'b1;
                d[WD_ENABLE]               = s.wd_en;
                d[WD_PARITY]               = ^d[7:0];
            end
            SEL_LIMP_DIAG: begin
                d[DIAG_RR_LO +: 2]         = s.restart;
                d[DIAG_LIMP_LO +: 3]       = s.limp;
                d[DIAG_CFG_LO +: 3]        = s.cfg_rd;
            end
            default: begin
                d = '0;
            end
        endcase
        return d;
    endfunction

    logic       sclk_rise;
    logic       cs_fall;
    logic       cs_rise;
    logic [2:0] rx_mode;
    logic [2:0] rx_sel;
    logic [9:0] rx_data;
    logic [9:0] tx_data;
    logic [15:0] tx_word;
    logic       is_ro;
    logic       ro_now;
    logic       parity_ok;
    logic       rr_clear;
    logic       limp_clear;
    logic       frame_ok;

    always_comb begin
        st_d         = st_q;
        sclk_rise    = pins[0] && !st_q.sclk_prev;
        cs_fall      = !pins[1] && st_q.cs_prev_n;
        cs_rise      = pins[1] && !st_q.cs_prev_n;
        rx_mode      = st_q.rx[2:0];
        rx_sel       = st_q.rx[5:3];
        rx_data      = st_q.rx[15:6];
        is_ro        = (rx_mode == MODE_READ_ONLY);
        frame_ok     = cs_rise && (st_q.bit_cnt == FRAME_BITS_C);
        parity_ok    = (rx_data[WD_PARITY] == ^rx_data[7:0]);
        rr_clear     = 1'b0;
        limp_clear   = 1'b0;
        st_d.sclk_prev = pins[0];
        st_d.cs_prev_n = pins[1];
        st_d.wd_trig   = 1'b0;
        st_d.wd_bad    = 1'b0;
        st_d.mode_stb  = 1'b0;

        // Serial receive, LSB first
        if (cs_fall) begin
            st_d.bit_cnt = '0;
            st_d.rx      = '0;
        end else if (!pins[1] && sclk_rise && st_q.bit_cnt < FRAME_BITS_C) begin
            st_d.rx[st_q.bit_cnt[3:0]] = pins[2];
            st_d.bit_cnt = st_q.bit_cnt + 5'h01;
        end

        // Serial transmit: read-only answers from its own select once known
        ro_now  = is_ro && (st_d.bit_cnt >= SELECT_DONE_C);
        tx_data = reg_data(ro_now ? st_d.rx[5:3] : st_q.prev_sel, st_q);
        tx_word = {tx_data, (ro_now ? st_d.rx[5:3] : st_q.prev_sel), i_sbc_mode};
        st_d.sdo_oe = !pins[1];
        st_d.sdo    = pins[1] ? 1'b0 : tx_word[st_d.bit_cnt[3:0]];

        // Commit at the end of a complete frame
        if (frame_ok) begin
            st_d.prev_sel = rx_sel;
            if (is_ro) begin
                st_d.wd_trig = 1'b1;
                rr_clear     = (rx_sel == SEL_LIMP_DIAG);
            end else begin
                st_d.mode_out = rx_mode;
                st_d.mode_stb = 1'b1;
                case (rx_sel)
                    SEL_SBC_CFG: begin
                        st_d.cfg[8:2] = rx_data[8:2];
                        if (rx_data[CFG_RT_LO +: 2] != RT_INVALID) begin
                            st_d.cfg[1:0] = rx_data[CFG_RT_LO +: 2];
                        end
                        limp_clear = st_q.cfg[CFG_LIMP_ON] && !rx_data[CFG_LIMP_ON];
                    end
                    SEL_COMM_SETUP: begin
                        st_d.slope    = rx_data[COMM_SLOPE];
                        st_d.can_mode = rx_data[COMM_CAN_LO +: 2];
                        st_d.lin_mode = rx_data[COMM_LIN_LO +: 2];
                    end
                    SEL_WD_SETUP: begin
                        if (parity_ok) begin
                            st_d.period = rx_data[WD_PERIOD_LO +: 5];
                            st_d.tonw   = rx_data[WD_TONW];
                            st_d.wd_en  = rx_data[WD_ENABLE];
                        end else begin
                            st_d.wd_bad = 1'b1;
                        end
                    end
                    default: begin
                        st_d.prev_sel = rx_sel;
                    end
                endcase
            end
        end

        // Period in ms from the stored code
        if (st_q.period[4]) begin
            st_d.period_ms = 11'(11'(st_q.period) * PERIOD_STEP_HI - PERIOD_OFFSET);
        end else begin
            st_d.period_ms = 11'((11'(st_q.period) + 11'h001) * PERIOD_STEP_LO);
        end

        // Diagnosis flags: a new event wins over a clear in the same cycle
        if (i_restart_set) begin
            st_d.restart = i_restart_code;
        end else if (rr_clear || i_leave_sleep_failsafe) begin
            st_d.restart = RR_NONE;
        end
        if (i_limp_set) begin
            st_d.limp = i_limp_code;
        end else if (limp_clear) begin
            st_d.limp = LIMP_NONE;
        end

        // Hardware configuration read-out
        st_d.cfg_rd = {i_test_pin, st_q.cfg[CFG_WD_TO_LIMP], i_supply_off_strap};
    end

    always_ff @(posedge i_mclk) begin
        if (!i_reset_n) begin
            st_q           <= '0;
            st_q.sclk_prev <= 1'b0;
            st_q.cs_prev_n <= 1'b1;
            st_q.prev_sel  <= SEL_SBC_CFG;
            st_q.cfg       <= CFG_RESET;
            st_q.slope     <= SLOPE_DEFAULT;
            st_q.can_mode  <= CELL_OFF;
            st_q.lin_mode  <= CELL_OFF;
            st_q.period    <= PERIOD_DEFAULT;
            st_q.tonw      <= TONW_DEFAULT;
            st_q.wd_en     <= WDEN_DEFAULT;
            st_q.period_ms <= PERIOD_MS_RESET;
            st_q.restart   <= RR_NONE;
            st_q.limp      <= LIMP_NONE;
        end else begin
            st_q <= st_d;
        end
    end

    assign o_spi_sdo               = st_q.sdo;
    assign o_spi_sdo_oe            = st_q.sdo_oe;
    assign o_lin_low_slope_sel     = st_q.slope;
    assign o_can_cell_mode         = st_q.can_mode;
    assign o_lin_cell_mode         = st_q.lin_mode;
    assign o_wd_timeout_not_window = st_q.tonw;
    assign o_wd_enable             = st_q.wd_en;
    assign o_wd_period_ms          = st_q.period_ms;
    assign o_reset_thresh          = st_q.cfg[1:0];
    assign o_limp_on               = st_q.cfg[CFG_LIMP_ON];
    assign o_sw_dev_mode           = st_q.cfg_rd[2];
    assign o_wd_trigger            = st_q.wd_trig;
    assign o_wd_bad_write          = st_q.wd_bad;
    assign o_mode_sel              = st_q.mode_out;
    assign o_mode_stb              = st_q.mode_stb;
endmodule

// >>> core/sbc_cfg_pkg.sv
/*
  Constants for the configuration and diagnosis register encoders: frame layout,
  select codes, field positions, reset values and encodings.
  Assumes a 16-bit SPI frame, LSB first, with mode bits [2:0], select [5:3], data [15:6].
*/
// Notes on behaviour
// - Slope bit set in setup register 101 puts all LIN cells in low slope; default one.
// - CAN mode field: 00 off, 01 wake capable, 10 receive only, 11 normal; default 00.
// - LIN mode field: 00 off, 01 wake capable, 10 receive only, 11 normal; default 00.
// - Watchdog register 110: mode bit picks time-out, on/off bit enables; both default one.
// - Checksum equals XOR of bits 13 to 6; bad checksum keeps previous watchdog settings.
// - Select 111 takes no write; reads return restart reason, limp cause, configuration.
// - Threshold field: 01 first (default), 10 second, 11 third; 00 keeps previous.
// - Period code n: below 16 gives (n+1)*16 ms, else n*48-464 ms; default 15.
// - Restart reason: 00 none, 01 supply undervoltage, 10 watchdog or wake, 11 flash or reset.
// - Restart reason clears on read-only read of select 111 and on leaving sleep or fail-safe.
// - Limp cause is a 3-bit code from none through reset clamped, then reserved.
// - Limp cause returns to 000 when limp-home output is switched off over SPI.
// - Configuration read-out: 000,001 one failure on/off; 010,011 two failures on/off.
// - Read-out top bit set means software development mode; watchdog failure is harmless.
// - Defaults hold until changed; current values are readable on the serial output.
// - Read-only returns selected register in same frame; other commands in the next frame.
// - Read-only writes nothing, changes no mode, clears read-clear bits, triggers watchdog.
package sbc_cfg_pkg;

    localparam int          FRAME_BITS      = 16;
    localparam logic [4:0]  FRAME_BITS_C    = 5'h10;
    localparam logic [4:0]  SELECT_DONE_C   = 5'h06;

    // Mode select codes
    localparam logic [2:0]  MODE_READ_ONLY  = 3'h0;

    // Configuration select codes
    localparam logic [2:0]  SEL_SBC_CFG     = 3'h4;
    localparam logic [2:0]  SEL_COMM_SETUP  = 3'h5;
    localparam logic [2:0]  SEL_WD_SETUP    = 3'h6;
    localparam logic [2:0]  SEL_LIMP_DIAG   = 3'h7;

    // Field positions within the 10-bit data field (frame bit minus 6)
    localparam int          CFG_RT_LO       = 0;
    localparam int          CFG_LIMP_ON     = 6;
    localparam int          CFG_WD_TO_LIMP  = 8;
    localparam int          COMM_SLOPE      = 0;
    localparam int          COMM_CAN_LO     = 1;
    localparam int          COMM_LIN_LO     = 3;
    localparam int          WD_PERIOD_LO    = 0;
    localparam int          WD_TONW         = 5;
    localparam int          WD_RSVD         = 6;
    localparam int          WD_ENABLE       = 7;
    localparam int          WD_PARITY       = 8;
    localparam int          DIAG_RR_LO      = 0;
    localparam int          DIAG_LIMP_LO    = 2;
    localparam int          DIAG_CFG_LO     = 5;

    // Reset values
    localparam logic [8:0]  CFG_RESET       = 9'h115;
    localparam logic [1:0]  RT_DEFAULT      = 2'h1;
    localparam logic [1:0]  RT_INVALID      = 2'h0;
    localparam logic        SLOPE_DEFAULT   = 1'h1;
    localparam logic [1:0]  CELL_OFF        = 2'h0;
    localparam logic        TONW_DEFAULT    = 1'h1;
    localparam logic        WDEN_DEFAULT    = 1'h1;
    localparam logic [4:0]  PERIOD_DEFAULT  = 5'h0f;
    localparam logic [1:0]  RR_NONE         = 2'h0;
    localparam logic [2:0]  LIMP_NONE       = 3'h0;

    // Watchdog period conversion, in ms
    localparam logic [10:0] PERIOD_STEP_LO  = 11'h010;
    localparam logic [10:0] PERIOD_STEP_HI  = 11'h030;
    localparam logic [10:0] PERIOD_OFFSET   = 11'h1d0;
    localparam logic [10:0] PERIOD_MS_RESET = 11'h100;

endpackage

// >>> core/pin_sync3.sv
/*
  Three-stage synchroniser for asynchronous pins, one generate block per bit.
  A new level is accepted once the second and third stages agree.
*/
`timescale 1ns/1ps
module pin_sync3 #(
    parameter int            W     = 3,
    parameter logic [W-1:0]  INIT  = '0
) (
    input  wire logic         i_mclk,
    input  wire logic         i_reset_n,
    input  wire logic [W-1:0] i_pin,
    output logic      [W-1:0] o_level
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] lvl;
    } sync_s;

    sync_s        st_q;
    sync_s        st_d;
    logic [W-1:0] lvl_next;

    // Per bit: take the new level only when the last two stages agree
    for (genvar g = 0; g < W; g++) begin : g_bit
        assign lvl_next[g] = (st_q.s2[g] == st_q.s3[g]) ? st_q.s3[g] : st_q.lvl[g];
    end

    always_comb begin
        st_d     = st_q;
        st_d.s1  = i_pin;
        st_d.s2  = st_q.s1;
        st_d.s3  = st_q.s2;
        st_d.lvl = lvl_next;
    end

    always_ff @(posedge i_mclk) begin
        if (!i_reset_n) begin
            st_q <= {INIT, INIT, INIT, INIT};
        end else begin
            st_q <= st_d;
        end
    end

    assign o_level = st_q.lvl;
endmodule

// >>> test/sbc_cfg_props.sv
/*
  Port checker of the configuration encoders.
  Assumes binding onto the top module, single clock, synchronous active-low reset.
*/
`timescale 1ns/1ps
module sbc_cfg_props (
    input wire logic        i_mclk,
    input wire logic        i_reset_n,
    input wire logic        i_spi_cs_n,
    input wire logic        i_test_pin,
    input wire logic        o_spi_sdo,
    input wire logic        o_spi_sdo_oe,
    input wire logic        o_lin_low_slope_sel,
    input wire logic [1:0]  o_can_cell_mode,
    input wire logic [1:0]  o_lin_cell_mode,
    input wire logic [1:0]  o_reset_thresh,
    input wire logic        o_wd_timeout_not_window,
    input wire logic        o_wd_enable,
    input wire logic [10:0] o_wd_period_ms,
    input wire logic        o_sw_dev_mode,
    input wire logic        o_wd_trigger,
    input wire logic        o_wd_bad_write,
    input wire logic [2:0]  o_mode_sel,
    input wire logic        o_mode_stb
);
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_reset_n);
    a_sdo_idle_low: assert property (i_spi_cs_n [*8] |-> !o_spi_sdo_oe && !o_spi_sdo)
        else $error("sdo active while deselected");
    a_oe_on_select: assert property ($fell(i_spi_cs_n) ##1 !i_spi_cs_n [*6] |-> o_spi_sdo_oe)
        else $error("sdo not enabled in frame");
    a_pulse_single: assert property (o_wd_trigger || o_mode_stb |=> !o_wd_trigger && !o_mode_stb)
        else $error("frame pulse too long");
    a_ro_no_mode: assert property (o_wd_trigger |-> !o_mode_stb && $stable(o_mode_sel))
        else $error("read-only frame changed mode");
    a_bad_keeps_wd: assert property (o_wd_bad_write |-> $stable({o_wd_enable, o_wd_timeout_not_window, o_wd_period_ms}) [*3])
        else $error("bad checksum changed watchdog");
    a_thresh_valid: assert property (o_reset_thresh != 2'h0)
        else $error("invalid reset threshold");
    a_period_legal: assert property (o_wd_period_ms[3:0] == 4'h0 && o_wd_period_ms != 11'h000
        && (o_wd_period_ms <= 11'h100 || (o_wd_period_ms + 11'h1d0) % 11'h030 == 11'h000))
        else $error("illegal watchdog period");
    a_cfg_frame_only: assert property (!i_spi_cs_n [*8] |-> $stable({o_lin_low_slope_sel, o_can_cell_mode,
        o_lin_cell_mode, o_reset_thresh, o_wd_enable}))
        else $error("setting changed mid-frame");
    a_dev_mode: assert property ($stable(i_test_pin) [*3] |-> o_sw_dev_mode == i_test_pin)
        else $error("development mode wrong");
endmodule

// >>> test/spi_master_model.sv
/*
  Microcontroller SPI master: mode 0, LSB first, 125 ns clock phases.
  Assumes the bench calls xfer; done pulses only after a complete 16-bit frame.
*/
`timescale 1ns/1ps
module spi_master_model (
    output logic        o_sclk,
    output logic        o_cs_n,
    output logic        o_sdi,
    input  wire logic   i_sdo,
    output logic [15:0] o_rx,
    output logic        o_done
);
    initial begin
        o_sclk = 1'b0;
        o_cs_n = 1'b1;
        o_sdi = 1'b0;
        o_rx = 16'h0000;
        o_done = 1'b0;
    end
    task automatic xfer(input logic [15:0] tx, input int n);
        o_cs_n = 1'b0;
        for (int i = 0; i < n; i++) begin
            o_sdi = tx[i];
            #125 o_sclk = 1'b1;
            o_rx[i] = i_sdo;
            #125 o_sclk = 1'b0;
        end
        // Pulled down once released
        o_sdi = 1'b0;
        #125 o_cs_n = 1'b1;
        o_done = (n == 16);
        #4 o_done = 1'b0;
        #250;
    endtask
endmodule

// >>> test/testbench.sv
/*
  Self-checking bench of the configuration encoders.
  Assumes the SPI master model drives the serial pins; other inputs driven at falling edges.
*/
`timescale 1ns/1ps
module testbench;
    import sbc_cfg_pkg::*;
    logic i_mclk, i_reset_n, i_spi_sclk, i_spi_cs_n, i_spi_sdi, i_restart_set, i_leave_sleep_failsafe;
    logic i_limp_set, i_test_pin, i_supply_off_strap, o_spi_sdo, o_spi_sdo_oe, o_lin_low_slope_sel, o_limp_on;
    logic o_wd_timeout_not_window, o_wd_enable, o_sw_dev_mode, o_wd_trigger, o_wd_bad_write, o_mode_stb, done;
    logic [2:0]  i_sbc_mode, i_limp_code, o_mode_sel, lc, prev_sel;
    logic [1:0]  i_restart_code, o_can_cell_mode, o_lin_cell_mode, o_reset_thresh, rr;
    logic [10:0] o_wd_period_ms;
    logic [15:0] rx;
    logic [9:0]  r_cfg, r_com, r_wd;
    logic [12:0] q[$];
    logic [4:0]  codes[5] = '{5'h00, 5'h0f, 5'h10, 5'h1f, 5'h07};
    logic [1:0]  rts[4] = '{2'h2, 2'h0, 2'h3, 2'h1};
    int mismatches, compares, cyc, bad_n, trig_n, s;
    sbc_config_diag_encoders u_sbc_config_diag_encoders (.*);
    spi_master_model u_spi_master_model (
        .o_sclk (i_spi_sclk),
        .o_cs_n (i_spi_cs_n),
        .o_sdi  (i_spi_sdi),
        .i_sdo  (o_spi_sdo),
        .o_rx   (rx),
        .o_done (done)
    );
    initial begin
        i_mclk = 1'b0;
        forever #2 i_mclk = ~i_mclk;
    end
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    function automatic logic [9:0] rv(input logic [2:0] sel);
        case (sel)
            SEL_SBC_CFG:    return r_cfg;
            SEL_COMM_SETUP: return r_com;
            SEL_WD_SETUP:   return r_wd;
            SEL_LIMP_DIAG:  return {2'h0, i_test_pin, r_cfg[CFG_WD_TO_LIMP], i_supply_off_strap, lc, rr};
            default:        return 10'h000;
        endcase
    endfunction
    function automatic logic [15:0] ms(input logic [4:0] n);
        return (n < 5'h10) ? ({11'h0, n} + 16'h1) * 16'h10 : {11'h0, n} * 16'h30 - 16'h1d0;
    endfunction
    function automatic logic [9:0] wd(input logic [4:0] n, input logic t, input logic en, input logic flip);
        logic [7:0] b;
        b = {en, 1'b1, t, n};
        return {1'b0, ^b ^ flip, b};
    endfunction
    task automatic chk_cfg();
        chk(o_lin_low_slope_sel, r_com[COMM_SLOPE]);
        chk(o_can_cell_mode, r_com[2:1]);
        chk(o_lin_cell_mode, r_com[4:3]);
        chk(o_wd_timeout_not_window, r_wd[WD_TONW]);
        chk(o_wd_enable, r_wd[WD_ENABLE]);
        chk(o_wd_period_ms, ms(r_wd[4:0]));
        chk(o_reset_thresh, r_cfg[1:0]);
        chk(o_limp_on, r_cfg[CFG_LIMP_ON]);
    endtask
    task automatic frame(input logic [2:0] m, input logic [2:0] sel, input logic [9:0] d, input int n = 16);
        if (n == 16) q.push_back({rv((m == MODE_READ_ONLY) ? sel : prev_sel), i_sbc_mode});
        u_spi_master_model.xfer({d, sel, m}, n);
        @(negedge i_mclk);
        if (n != 16) return;
        prev_sel = sel;
        if (m == MODE_READ_ONLY) begin
            if (sel == SEL_LIMP_DIAG) rr = RR_NONE;
        end else if (sel == SEL_SBC_CFG) begin
            if (r_cfg[CFG_LIMP_ON] && !d[CFG_LIMP_ON]) lc = LIMP_NONE;
            r_cfg = {1'b0, d[8:2], (d[1:0] == RT_INVALID) ? r_cfg[1:0] : d[1:0]};
        end else if (sel == SEL_COMM_SETUP) r_com = {5'h00, d[4:0]};
        else if (sel == SEL_WD_SETUP && d[8] == ^d[7:0]) r_wd = {1'b0, d[8:0]};
    endtask
    task automatic diag(input logic rs, input logic [1:0] rc, input logic ls, input logic [2:0] lcd, input logic lv);
        @(negedge i_mclk);
        i_restart_set = rs;
        i_restart_code = rc;
        i_limp_set = ls;
        i_limp_code = lcd;
        i_leave_sleep_failsafe = lv;
        @(negedge i_mclk);
        {i_restart_set, i_limp_set, i_leave_sleep_failsafe} = 3'h0;
        if (rs) rr = rc;
        else if (lv) rr = RR_NONE;
        if (ls) lc = lcd;
    endtask
    always @(posedge done) chk({3'h0, rx[15:6], rx[2:0]}, {3'h0, q.pop_front()});
    always @(negedge i_mclk) begin
        bad_n += int'(o_wd_bad_write);
        trig_n += int'(o_wd_trigger);
    end
    always @(posedge i_mclk) begin
        cyc++;
        if (cyc == 90000) begin
            mismatches++;
            wrap_up();
        end
    end
    initial begin
        {i_reset_n, i_restart_set, i_leave_sleep_failsafe, i_limp_set, i_test_pin, i_supply_off_strap} = 6'h00;
        i_restart_code = 2'h0;
        i_limp_code = 3'h0;
        s = $urandom(32'h062fe1bf);
        i_sbc_mode = 3'($urandom);
        codes[4] = 5'($urandom);
        r_cfg = {1'b0, CFG_RESET};
        r_com = {5'h00, CELL_OFF, CELL_OFF, SLOPE_DEFAULT};
        r_wd = wd(PERIOD_DEFAULT, TONW_DEFAULT, WDEN_DEFAULT, 1'b0);
        rr = RR_NONE;
        lc = LIMP_NONE;
        prev_sel = SEL_SBC_CFG;
        repeat (3) @(negedge i_mclk);
        i_reset_n = 1'b1;
        repeat (5) @(negedge i_mclk);
        chk_cfg();
        frame(MODE_READ_ONLY, SEL_SBC_CFG, 10'h000);
        $display("defaults test done");
        for (int m = 0; m < 4; m++) frame(3'($urandom_range(7, 1)), SEL_COMM_SETUP, {5'h00, 2'(m), 2'(3 - m), 1'($urandom)});
        chk_cfg();
        frame(3'h1, SEL_COMM_SETUP, 10'h01e, 15);
        chk_cfg();
        $display("setup test done");
        foreach (codes[i]) begin
            frame(3'h1, SEL_WD_SETUP, wd(codes[i], 1'($urandom), 1'($urandom), 1'b0));
            chk_cfg();
        end
        s = bad_n;
        frame(3'h1, SEL_WD_SETUP, wd(5'h03, 1'b0, 1'b0, 1'b1));
        chk_cfg();
        chk(16'(bad_n), 16'(s + 1));
        $display("watchdog test done");
        foreach (rts[i]) begin
            frame(3'h2, SEL_SBC_CFG, {1'b0, 1'(i), 2'h1, 4'h3, rts[i]});
            chk_cfg();
        end
        diag(1'b0, 2'h0, 1'b1, 3'h5, 1'b0);
        frame(MODE_READ_ONLY, SEL_LIMP_DIAG, 10'h000);
        frame(3'h2, SEL_SBC_CFG, 10'h10d);
        frame(MODE_READ_ONLY, SEL_LIMP_DIAG, 10'h000);
        $display("threshold test done");
        s = trig_n;
        for (int i = 0; i < 8; i++) begin
            @(negedge i_mclk);
            i_test_pin = i[2];
            i_supply_off_strap = i[0];
            diag(1'b1, 2'(i), 1'b1, 3'(i), 1'b0);
            frame(MODE_READ_ONLY, SEL_LIMP_DIAG, 10'h000);
            frame(MODE_READ_ONLY, SEL_LIMP_DIAG, 10'h000);
            chk(o_sw_dev_mode, i[2]);
        end
        chk(16'(trig_n), 16'(s + 16));
        chk(o_mode_sel, 3'h2);
        diag(1'b1, 2'h3, 1'b0, 3'h0, 1'b0);
        diag(1'b0, 2'h0, 1'b0, 3'h0, 1'b1);
        frame(3'h1, SEL_LIMP_DIAG, 10'h3ff);
        frame(MODE_READ_ONLY, SEL_LIMP_DIAG, 10'h000);
        frame(MODE_READ_ONLY, 3'h3, 10'h000);
        chk_cfg();
        $display("diagnosis test done");
        wrap_up();
    end
endmodule
bind sbc_config_diag_encoders sbc_cfg_props u_sbc_cfg_props (.*);
